// ==== bench/rsc_far_model.sv ====
// Far side model: outside pin levels and the low-frequency crystal.
`timescale 1ns/1ps
module rsc_far_model #(
   parameter int SETTLE = 8
) (
   input wire logic clk,
   input wire logic [1:0] oe,
   input wire logic [1:0] o,
   input wire logic [1:0] ext,
   input wire logic osc_en,
   output logic [1:0] pin,
   output logic osc_ok
);
   int cnt = 0;
   // The crystal reports settled only after SETTLE cycles of running.
   always @(posedge clk) begin
      cnt <= osc_en ? cnt + 1 : 0;
      osc_ok <= osc_en && cnt >= SETTLE;
   end
   // A running crystal swings both pins; otherwise output bits win over the outside level.
   assign pin = osc_en ? {cnt[0], ~cnt[0]} : (oe & o) | (~oe & ext);
endmodule

// ==== bench/rsc_top_bench.sv ====
// Self-checking bench for the reset and sub-clock port controller.
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin n_mismatch++; \
   $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
`define WAITN(c, m) begin n = 0; @(negedge clk); while (!(c) && n < (m)) begin \
   @(negedge clk); n++; end @(posedge clk); end
module rsc_top_bench import rsc_pkg::*;;
   localparam int SB = 20;
   localparam int GP = 4;
   typedef struct packed {logic [12:0] c; logic [10:0] e;} rsc_row_t;
   rsc_row_t rows [6] = '{'{13'h0C1, 11'h280}, '{13'h01C, 11'h030}, '{13'h0BF, 11'h700},
      '{13'h203, 11'h004}, '{13'h403, 11'h006}, '{13'h6C3, 11'h501}};
   logic clk = 1'b0, rst = 1'b1, rst_pin_n = 1'b1, ok, sg = 1'b0;
   logic clock_halt_instruction = 1'b0, wait_instruction = 1'b0;
   logic [1:0] ext = 2'h0, sub_osc_port_i, sub_osc_port_o, sub_osc_port_oe, rsp;
   logic [1:0] pull_up_en, pull_dn_en, s_axi_bresp, s_axi_rresp;
   logic sys_reset, main_osc_en, sub_xtal_en, sub_xtal_32k, rc_osc_en, clk_main_gate;
   logic clk_sub_gate, cpu_run, cpu_start, cd_standby;
   logic [12:0] cpu_boot_addr;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rdat;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   int n_mismatch = 0, checks = 0, cyc = 0, gap = 0, n, i;
   wire [10:0] pins = {sub_osc_port_oe, sub_osc_port_o, pull_up_en, pull_dn_en, sub_xtal_en,
      sub_xtal_32k, rc_osc_en};

   rsc_top #(.STANDBY_CYC(SB), .GAP_CYC(GP)) rsc_top_i (.*);
   rsc_far_model rsc_far_model_i (.clk(clk), .oe(sub_osc_port_oe), .o(sub_osc_port_o),
      .ext(ext), .osc_en(sub_xtal_en), .pin(sub_osc_port_i), .osc_ok(ok));

   // Free-running clock.
   initial begin
      forever #4 clk = ~clk;
   end
   // Cycle ceiling against hangs.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   // Gate watch at the falling edge, where the gates are settled.
   always @(negedge clk) begin
      sg <= clk_sub_gate;
      gap <= (clk_main_gate | clk_sub_gate) ? 0 : gap + 1;
      if (clk_main_gate && clk_sub_gate) `CHK(1'b1, 1'b0)
      if (clk_sub_gate && !sg) `CHK(gap >= GP, 1'b1)
   end

   // Register write: address and data together, each dropped once taken.
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      logic [2:0] h;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(negedge clk);
         h = {s_axi_awready & s_axi_awvalid, s_axi_wready & s_axi_wvalid, s_axi_bvalid};
         rsp = s_axi_bresp;
         @(posedge clk);
         if (h[2]) s_axi_awvalid <= 1'b0;
         if (h[1]) s_axi_wvalid <= 1'b0;
      end while (!h[0]);
      s_axi_bready <= 1'b0;
      @(posedge clk);
   endtask
   // Register read; data and response are taken at the falling edge before the handshake edge.
   task automatic rd(input logic [3:0] a);
      logic [1:0] h;
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(negedge clk);
         h = {s_axi_arready & s_axi_arvalid, s_axi_rvalid};
         rsp = s_axi_rresp;
         rdat = s_axi_rdata;
         @(posedge clk);
         if (h[1]) s_axi_arvalid <= 1'b0;
      end while (!h[0]);
      s_axi_rready <= 1'b0;
      @(posedge clk);
   endtask
   // Starts the crystal, lets it settle, then asks for the sub clock.
   task automatic to_sub();
      wr(RSC_OFS_CTRL, 32'h0000_1200);
      `WAITN(ok === 1'b1, 40)
      wr(RSC_OFS_CTRL, 32'h0000_1A00);
      `WAITN(clk_sub_gate === 1'b1, GP + 8)
      `CHK({clk_sub_gate, clk_main_gate}, 2'h2)
   endtask
   // One-cycle halt or wait pulse.
   task automatic pulse(input logic w);
      wait_instruction <= w;
      clock_halt_instruction <= ~w;
      @(posedge clk);
      wait_instruction <= 1'b0;
      clock_halt_instruction <= 1'b0;
   endtask
   // Prints the counts and the verdict, then ends the run.
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   // Main sequence: start-up, table of port set-ups, then the awkward cases.
   initial begin
      repeat (10) @(posedge clk);
      `CHK({sys_reset, cd_standby, clk_main_gate, main_osc_en, sub_osc_port_oe}, 6'h38)
      rst <= 1'b0;
      `WAITN(sys_reset === 1'b0, 20)
      `WAITN(cpu_start === 1'b1, SB + 10)
      `CHK((n >= SB - 2) && (n <= SB + 2), 1'b1)
      `CHK({main_osc_en, cpu_run, cd_standby, cpu_boot_addr}, {3'h7, RSC_BOOT_ADDR})
      $display("start-up done");
      for (i = 0; i < 6; i++) begin
         wr(RSC_OFS_CTRL, {19'h0, rows[i].c});
         `CHK(pins, rows[i].e)
         rd(RSC_OFS_CTRL);
         `CHK(rdat, {19'h0, rows[i].c})
      end
      rd(4'h8);
      `CHK({rsp, rdat}, {RSC_RESP_SLVERR, 32'h0})
      wr(4'h8, 32'h0000_1FFF);
      `CHK(rsp, RSC_RESP_SLVERR)
      rd(RSC_OFS_CTRL);
      `CHK(rdat, {19'h0, rows[5].c})
      $display("port table done");
      to_sub();
      pulse(1'b0);
      `WAITN(sub_xtal_en === 1'b0, 6)
      `CHK({sub_xtal_en, main_osc_en, cpu_run}, 3'h0)
      wr(RSC_OFS_CTRL, 32'h0000_1100);
      repeat (12) @(posedge clk);
      `CHK(cpu_run, 1'b0)
      ext <= 2'h2;
      `WAITN(cpu_start === 1'b1, SB + 12)
      `CHK(n < SB + 12, 1'b1)
      rd(RSC_OFS_STAT);
      `CHK(rdat[RSC_ST_WAKE], 1'b1)
      wr(RSC_OFS_STAT, 32'h0000_0004);
      `CHK(rsp, RSC_RESP_OKAY)
      rd(RSC_OFS_STAT);
      `CHK(rdat, 32'h0000_0022)
      wr(RSC_OFS_CTRL, 32'h0000_1000);
      pulse(1'b1);
      ext <= 2'h3;
      repeat (12) @(posedge clk);
      `CHK(cpu_run, 1'b0)
      wr(RSC_OFS_CTRL, 32'h0000_1100);
      ext <= 2'h2;
      `WAITN(cpu_run === 1'b1, 12)
      `CHK(cpu_run, 1'b1)
      $display("halt and wait done");
      to_sub();
      rst_pin_n <= 1'b0;
      repeat (30) @(posedge clk);
      `CHK({sys_reset, cpu_run, sub_xtal_en, cd_standby, clk_main_gate, clk_sub_gate}, 6'h26)
      rd(RSC_OFS_CTRL);
      `CHK({rdat, sub_osc_port_oe}, 34'h0)
      rst_pin_n <= 1'b1;
      `WAITN(cpu_start === 1'b1, SB + 20)
      `CHK({cpu_run, cd_standby}, 2'h3)
      $display("pin reset done");
      report_and_stop();
   end
endmodule

// ==== core/rsc_clk_if.sv ====
// Handshake between the controller and the clock source switch.
`timescale 1ns/1ps
interface rsc_clk_if;
   logic req_sub;
   logic force_main;
   logic main_en;
   logic sub_en;
   modport ctl(output req_sub, output force_main, input main_en, input sub_en);
   modport mux(input req_sub, input force_main, output main_en, output sub_en);
endinterface

// ==== core/rsc_clk_mux.sv ====
// Break-before-make sequencer for the controller clock source gates.
`timescale 1ns/1ps
module rsc_clk_mux import rsc_pkg::*; #(
   parameter int unsigned GAP_CYC = RSC_GAP_CYC
) (
   input wire logic clk,
   input wire logic rst,
   rsc_clk_if.mux sw
);
   typedef enum logic [1:0] {RSC_M_MAIN, RSC_M_GAP, RSC_M_SUB} rsc_mux_state_t;
   typedef struct packed {
      rsc_mux_state_t state;
      logic target;
      logic [RSC_GAP_W-1:0] cnt;
      logic main_en;
      logic sub_en;
   } rsc_mux_st_t;

   rsc_mux_st_t r_reg;
   rsc_mux_st_t r_next;

   // One gate closes, both stay closed for the gap, then the target opens; force_main during the gap makes that target main.
   always_comb begin
      r_next = r_reg;
      case (r_reg.state)
         RSC_M_MAIN: begin
            if (sw.req_sub && !sw.force_main) begin
               r_next.main_en = 1'b0;
               r_next.target = 1'b1;
               r_next.cnt = '0;
               r_next.state = RSC_M_GAP;
            end
         end
         RSC_M_SUB: begin
            if (!sw.req_sub || sw.force_main) begin
               r_next.sub_en = 1'b0;
               r_next.target = 1'b0;
               r_next.cnt = '0;
               r_next.state = RSC_M_GAP;
            end
         end
         RSC_M_GAP: begin
            r_next.cnt = r_reg.cnt + 1'b1;
            if (sw.force_main) begin
               r_next.target = 1'b0;
            end
            if (r_reg.cnt == RSC_GAP_W'(GAP_CYC - 1)) begin
               r_next.main_en = !r_next.target;
               r_next.sub_en = r_next.target;
               r_next.state = r_next.target ? RSC_M_SUB : RSC_M_MAIN;
            end
         end
         default: begin
            r_next.state = RSC_M_MAIN;
         end
      endcase
   end

   // State register; the main source is the one in use out of reset.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_reg <= '{RSC_M_MAIN, 1'b0, '0, 1'b1, 1'b0};
      end else begin
         r_reg <= r_next;
      end
   end

   assign sw.main_en = r_reg.main_en;
   assign sw.sub_en = r_reg.sub_en;

   property p_never_both;
      @(posedge clk) disable iff (rst) !(r_reg.main_en && r_reg.sub_en);
   endproperty
   a_never_both: assert property (p_never_both) else $error("both clock gates open");

   property p_gap_before_sub;
      @(posedge clk) disable iff (rst)
         $rose(r_reg.sub_en) |-> !$past(r_reg.main_en) && !$past(r_reg.main_en, 2);
   endproperty
   a_gap_before_sub: assert property (p_gap_before_sub) else $error("no gap before sub");
endmodule

// ==== core/rsc_pkg.sv ====
// Shared constants and types for the reset and sub-clock port controller.
package rsc_pkg;
   localparam int unsigned RSC_CLK_HZ = 125_000_000;
   localparam int unsigned RSC_MS_PER_S = 1000;
   localparam int unsigned RSC_STANDBY_MS = 50;
   localparam int unsigned RSC_STANDBY_CYC = RSC_CLK_HZ / RSC_MS_PER_S * RSC_STANDBY_MS;
   localparam int RSC_CNT_W = 24;
   localparam int RSC_PORT_W = 2;
   localparam int RSC_BOOT_W = 13;
   localparam logic [RSC_BOOT_W-1:0] RSC_BOOT_ADDR = 13'h0000;
   localparam int unsigned RSC_GAP_CYC = 4;
   localparam int RSC_GAP_W = 4;
   localparam int RSC_ADDR_W = 4;
   localparam int RSC_BYTE_W = 8;
   localparam int RSC_STRB_W = 4;
   localparam logic [RSC_ADDR_W-1:0] RSC_OFS_CTRL = 4'h0;
   localparam logic [RSC_ADDR_W-1:0] RSC_OFS_STAT = 4'h4;
   localparam logic [1:0] RSC_RESP_OKAY = 2'h0;
   localparam logic [1:0] RSC_RESP_SLVERR = 2'h2;
   localparam int RSC_ST_PIN_LSB = 0;
   localparam int RSC_ST_WAKE = 2;
   localparam int RSC_ST_SUB = 3;
   localparam int RSC_ST_CDSB = 4;
   localparam int RSC_ST_RUN = 5;

   // Use of the two shared pins.
   typedef enum logic [1:0] {RSC_OSC_PORT, RSC_OSC_X75K, RSC_OSC_X32K, RSC_OSC_RC} rsc_osc_t;

   // Control register layout, bit 0 upward from dir.
   typedef struct packed {
      logic cd_active;
      logic clk_sub;
      rsc_osc_t osc_mode;
      logic wake_en;
      logic [RSC_PORT_W-1:0] out;
      logic [RSC_PORT_W-1:0] pull_up;
      logic [RSC_PORT_W-1:0] pull_en;
      logic [RSC_PORT_W-1:0] dir;
   } rsc_ctrl_t;

   localparam rsc_ctrl_t RSC_CTRL_RST = '0;

   typedef enum logic [2:0] {RSC_S_RESET, RSC_S_STANDBY, RSC_S_RUN, RSC_S_HALT, RSC_S_WAIT}
      rsc_state_t;
endpackage

// ==== core/rsc_sync3.sv ====
// Three-stage input synchroniser that accepts a level once stages two and three agree.
`timescale 1ns/1ps
module rsc_sync3 import rsc_pkg::*; #(
   parameter int W = 1,
   parameter logic [W-1:0] RST_VAL = '0
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] q;
   } rsc_sync_st_t;

   rsc_sync_st_t r_reg;
   rsc_sync_st_t r_next;

   // The first stage feeds only the second; the output moves where the later two agree.
   always_comb begin
      r_next = r_reg;
      r_next.s1 = d;
      r_next.s2 = r_reg.s1;
      r_next.s3 = r_reg.s2;
      r_next.q = (r_reg.s2 & ~(r_reg.s2 ^ r_reg.s3)) | (r_reg.q & (r_reg.s2 ^ r_reg.s3));
   end

   // State register.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_reg <= {RST_VAL, RST_VAL, RST_VAL, RST_VAL};
      end else begin
         r_reg <= r_next;
      end
   end

   assign q = r_reg.q;
endmodule

// ==== core/rsc_top.sv ====
// Reset start-up, controller clock choice and two-bit sub-oscillator port.
//
// Behaviour
// - While the reset pin is low the whole system is held in reset.
// - When the reset pin returns high the main crystal oscillator is enabled.
// - After release a standby count of about 50 ms runs, then the controller starts at 0.
// - Reset puts the disc section in standby until software activates it.
// - Each of the two port bits is set as input or output on its own.
// - A port bit used as input may have a pull-up or a pull-down attached.
// - With wake enabled, a level change on a port input ends clock-stop or wait.
// - One wake enable covers both pins together.
// - Software may turn the pins into a 75 kHz or 32.768 kHz crystal oscillator.
// - With only bit 0 used as RC oscillator input, bit 1 stays an ordinary port bit.
// - Any system reset selects the main crystal clock for controller and peripherals.
// - Once the pins are set to oscillator use, the controller clock may switch to it.
// - In oscillator use the clock-halt instruction stops that oscillator.
// - System reset returns both pins to port inputs whatever they were before.
//
// Register access over AXI4-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
module rsc_top import rsc_pkg::*; #(
   parameter int unsigned STANDBY_CYC = RSC_STANDBY_CYC,
   parameter int unsigned GAP_CYC = RSC_GAP_CYC
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic rst_pin_n,
   input wire logic [RSC_PORT_W-1:0] sub_osc_port_i,
   output logic [RSC_PORT_W-1:0] sub_osc_port_o,
   output logic [RSC_PORT_W-1:0] sub_osc_port_oe,
   output logic [RSC_PORT_W-1:0] pull_up_en,
   output logic [RSC_PORT_W-1:0] pull_dn_en,
   input wire logic clock_halt_instruction,
   input wire logic wait_instruction,
   output logic sys_reset,
   output logic main_osc_en,
   output logic sub_xtal_en,
   output logic sub_xtal_32k,
   output logic rc_osc_en,
   output logic clk_main_gate,
   output logic clk_sub_gate,
   output logic cpu_run,
   output logic cpu_start,
   output logic [RSC_BOOT_W-1:0] cpu_boot_addr,
   output logic cd_standby,
   input wire logic [RSC_ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [RSC_STRB_W-1:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [RSC_ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);
   typedef struct packed {
      rsc_state_t state;
      logic [RSC_CNT_W-1:0] cnt;
      rsc_ctrl_t ctrl;
      logic wake_flag;
      logic [RSC_PORT_W-1:0] pin_prev;
      logic aw_got;
      logic [RSC_ADDR_W-1:0] aw_addr;
      logic w_got;
      logic [31:0] w_data;
      logic [RSC_STRB_W-1:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      logic sys_reset;
      logic main_osc_en;
      logic sub_xtal_en;
      logic sub_xtal_32k;
      logic rc_osc_en;
      logic req_sub;
      logic cpu_run;
      logic cpu_start;
      logic [RSC_BOOT_W-1:0] boot_addr;
      logic cd_standby;
      logic [RSC_PORT_W-1:0] pin_o;
      logic [RSC_PORT_W-1:0] pin_oe;
      logic [RSC_PORT_W-1:0] pu;
      logic [RSC_PORT_W-1:0] pd;
   } rsc_top_st_t;

   rsc_top_st_t r_reg;
   rsc_top_st_t r_next;

   logic rst_pin_q;
   logic [RSC_PORT_W-1:0] pin_q;
   logic sys_rst;
   logic [RSC_PORT_W-1:0] use_now;
   logic [RSC_PORT_W-1:0] use_next;
   logic [RSC_PORT_W-1:0] pin_chg;
   logic wake;
   logic wr_ctrl;
   logic wr_stat;
   logic [31:0] wr_bits;
   logic [31:0] stat;
   logic sub_run;

   rsc_clk_if sw();

   // Returns which pins act as port bits for a given pin use.
   function automatic logic [RSC_PORT_W-1:0] port_use(input rsc_osc_t mode);
      logic [RSC_PORT_W-1:0] m;
      m = '0;
      case (mode)
         RSC_OSC_PORT: m = '1;
         RSC_OSC_RC: m = 2'h2;
         default: m = '0;
      endcase
      return m;
   endfunction

   // Merges write data into an old word under the byte strobes.
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                         input logic [RSC_STRB_W-1:0] s);
      logic [31:0] v;
      v = old;
      for (int i = 0; i < RSC_STRB_W; i++) begin
         if (s[i]) begin
            v[i*RSC_BYTE_W +: RSC_BYTE_W] = d[i*RSC_BYTE_W +: RSC_BYTE_W];
         end
      end
      return v;
   endfunction

   // Reset pin and port pins arrive from outside the clock domain.
   rsc_sync3 #(.W(1), .RST_VAL(1'b0)) u_rst_sync (
      .clk(clk),
      .rst(rst),
      .d(rst_pin_n),
      .q(rst_pin_q)
   );

   rsc_sync3 #(.W(RSC_PORT_W), .RST_VAL('0)) u_pin_sync (
      .clk(clk),
      .rst(rst),
      .d(sub_osc_port_i),
      .q(pin_q)
   );

   rsc_clk_mux #(.GAP_CYC(GAP_CYC)) u_clk_mux (
      .clk(clk),
      .rst(rst),
      .sw(sw)
   );

   assign sys_rst = !rst_pin_q;
   assign sw.req_sub = r_reg.req_sub;
   assign sw.force_main = r_reg.sys_reset;

   // Status word as software reads it.
   always_comb begin
      stat = '0;
      stat[RSC_ST_PIN_LSB +: RSC_PORT_W] = pin_q;
      stat[RSC_ST_WAKE] = r_reg.wake_flag;
      stat[RSC_ST_SUB] = sw.sub_en;
      stat[RSC_ST_CDSB] = r_reg.cd_standby;
      stat[RSC_ST_RUN] = r_reg.cpu_run;
   end

   // Bus slave, start-up sequencer, backup modes and pin drive.
   always_comb begin
      r_next = r_reg;
      r_next.cpu_start = 1'b0;
      use_now = port_use(r_reg.ctrl.osc_mode);
      pin_chg = (pin_q ^ r_reg.pin_prev) & use_now & ~r_reg.ctrl.dir;
      r_next.pin_prev = pin_q;
      wake = r_reg.ctrl.wake_en && (|pin_chg);
      wr_ctrl = 1'b0;
      wr_stat = 1'b0;
      wr_bits = merge(32'(r_reg.ctrl), r_reg.w_data, r_reg.w_strb);

      // Write address and data may arrive in either order.
      if (s_axi_awvalid && r_reg.awready) begin
         r_next.aw_got = 1'b1;
         r_next.aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && r_reg.wready) begin
         r_next.w_got = 1'b1;
         r_next.w_data = s_axi_wdata;
         r_next.w_strb = s_axi_wstrb;
      end
      if (r_reg.bvalid && s_axi_bready) begin
         r_next.bvalid = 1'b0;
      end
      if (r_reg.aw_got && r_reg.w_got && !r_reg.bvalid) begin
         r_next.aw_got = 1'b0;
         r_next.w_got = 1'b0;
         r_next.bvalid = 1'b1;
         r_next.bresp = RSC_RESP_OKAY;
         case (r_reg.aw_addr)
            RSC_OFS_CTRL: wr_ctrl = 1'b1;
            RSC_OFS_STAT: wr_stat = 1'b1;
            default: r_next.bresp = RSC_RESP_SLVERR;
         endcase
      end
      if (wr_ctrl) begin
         r_next.ctrl = rsc_ctrl_t'(wr_bits[$bits(rsc_ctrl_t)-1:0]);
      end
      if (wr_stat && r_reg.w_strb[0] && r_reg.w_data[RSC_ST_WAKE]) begin
         r_next.wake_flag = 1'b0;
      end

      // Reads answer one cycle after the address is taken.
      if (r_reg.rvalid && s_axi_rready) begin
         r_next.rvalid = 1'b0;
      end
      if (s_axi_arvalid && r_reg.arready) begin
         r_next.rvalid = 1'b1;
         r_next.rresp = RSC_RESP_OKAY;
         case (s_axi_araddr)
            RSC_OFS_CTRL: r_next.rdata = 32'(r_reg.ctrl);
            RSC_OFS_STAT: r_next.rdata = stat;
            default: begin
               r_next.rdata = '0;
               r_next.rresp = RSC_RESP_SLVERR;
            end
         endcase
      end

      // Start-up and backup sequencing.
      case (r_reg.state)
         RSC_S_RESET: begin
            r_next.cnt = '0;
            r_next.state = RSC_S_STANDBY;
         end
         RSC_S_STANDBY: begin
            r_next.cnt = r_reg.cnt + 1'b1;
            if (r_reg.cnt == RSC_CNT_W'(STANDBY_CYC - 1)) begin
               r_next.state = RSC_S_RUN;
               r_next.cpu_start = 1'b1;
               r_next.boot_addr = RSC_BOOT_ADDR;
            end
         end
         RSC_S_RUN: begin
            if (clock_halt_instruction) begin
               r_next.state = RSC_S_HALT;
            end else if (wait_instruction) begin
               r_next.state = RSC_S_WAIT;
            end
         end
         RSC_S_HALT: begin
            // The main crystal was stopped, so it gets its standby count again.
            if (wake) begin
               r_next.cnt = '0;
               r_next.state = RSC_S_STANDBY;
            end
         end
         RSC_S_WAIT: begin
            if (wake) begin
               r_next.state = RSC_S_RUN;
            end
         end
         default: begin
            r_next.state = RSC_S_RESET;
         end
      endcase

      // Set wins over a clear in the same cycle.
      if (wake && (r_reg.state == RSC_S_HALT || r_reg.state == RSC_S_WAIT)) begin
         r_next.wake_flag = 1'b1;
      end

      // System reset overrides state, count, control, wake flag and boot address; cpu_start and the bus handshake are left alone.
      if (sys_rst) begin
         r_next.state = RSC_S_RESET;
         r_next.cnt = '0;
         r_next.ctrl = RSC_CTRL_RST;
         r_next.wake_flag = 1'b0;
         r_next.boot_addr = RSC_BOOT_ADDR;
      end

      // Outputs follow the next state so they leave straight from flip-flops.
      r_next.sys_reset = sys_rst;
      r_next.main_osc_en = !sys_rst && (r_next.state != RSC_S_HALT);
      sub_run = (r_next.state != RSC_S_HALT);
      r_next.sub_xtal_en = sub_run && (r_next.ctrl.osc_mode == RSC_OSC_X75K ||
                                       r_next.ctrl.osc_mode == RSC_OSC_X32K);
      r_next.sub_xtal_32k = (r_next.ctrl.osc_mode == RSC_OSC_X32K);
      r_next.rc_osc_en = sub_run && (r_next.ctrl.osc_mode == RSC_OSC_RC);
      // Switching is only asked for while the pins run an oscillator; settling is up to software.
      r_next.req_sub = r_next.ctrl.clk_sub && (r_next.ctrl.osc_mode != RSC_OSC_PORT) &&
                       sub_run;
      r_next.cpu_run = (r_next.state == RSC_S_RUN);
      r_next.cd_standby = !r_next.ctrl.cd_active;
      use_next = port_use(r_next.ctrl.osc_mode);
      r_next.pin_oe = use_next & r_next.ctrl.dir;
      r_next.pin_o = r_next.ctrl.out & r_next.pin_oe;
      r_next.pu = use_next & ~r_next.ctrl.dir & r_next.ctrl.pull_en & r_next.ctrl.pull_up;
      r_next.pd = use_next & ~r_next.ctrl.dir & r_next.ctrl.pull_en & ~r_next.ctrl.pull_up;
      r_next.awready = !r_next.aw_got && !r_next.bvalid;
      r_next.wready = !r_next.w_got && !r_next.bvalid;
      r_next.arready = !r_next.rvalid;
   end

   // State register; all but the bus slave stays in reset until the pin has been seen high.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r_reg <= '0;
         r_reg.state <= RSC_S_RESET;
         r_reg.ctrl <= RSC_CTRL_RST;
         r_reg.sys_reset <= 1'b1;
         r_reg.cd_standby <= 1'b1;
         r_reg.boot_addr <= RSC_BOOT_ADDR;
      end else begin
         r_reg <= r_next;
      end
   end

   assign sys_reset = r_reg.sys_reset;
   assign main_osc_en = r_reg.main_osc_en;
   assign sub_xtal_en = r_reg.sub_xtal_en;
   assign sub_xtal_32k = r_reg.sub_xtal_32k;
   assign rc_osc_en = r_reg.rc_osc_en;
   assign clk_main_gate = sw.main_en;
   assign clk_sub_gate = sw.sub_en;
   assign cpu_run = r_reg.cpu_run;
   assign cpu_start = r_reg.cpu_start;
   assign cpu_boot_addr = r_reg.boot_addr;
   assign cd_standby = r_reg.cd_standby;
   assign sub_osc_port_o = r_reg.pin_o;
   assign sub_osc_port_oe = r_reg.pin_oe;
   assign pull_up_en = r_reg.pu;
   assign pull_dn_en = r_reg.pd;
   assign s_axi_awready = r_reg.awready;
   assign s_axi_wready = r_reg.wready;
   assign s_axi_bvalid = r_reg.bvalid;
   assign s_axi_bresp = r_reg.bresp;
   assign s_axi_arready = r_reg.arready;
   assign s_axi_rvalid = r_reg.rvalid;
   assign s_axi_rdata = r_reg.rdata;
   assign s_axi_rresp = r_reg.rresp;

   property p_hold_reset;
      @(posedge clk) disable iff (rst) sys_rst |=> r_reg.sys_reset && !r_reg.cpu_run;
   endproperty
   a_hold_reset: assert property (p_hold_reset) else $error("reset not held");

   property p_osc_start;
      @(posedge clk) disable iff (rst) $fell(sys_rst) |=> r_reg.main_osc_en;
   endproperty
   a_osc_start: assert property (p_osc_start) else $error("main osc not started");

   property p_boot;
      @(posedge clk) disable iff (rst)
         (r_reg.state == RSC_S_STANDBY && r_reg.cnt == RSC_CNT_W'(STANDBY_CYC - 1) && !sys_rst)
         |=> r_reg.cpu_start && r_reg.cpu_run && r_reg.boot_addr == RSC_BOOT_ADDR;
   endproperty
   a_boot: assert property (p_boot) else $error("no start after standby count");

   property p_cd_standby;
      @(posedge clk) disable iff (rst) sys_rst |=> r_reg.cd_standby ##1 r_reg.cd_standby;
   endproperty
   a_cd_standby: assert property (p_cd_standby) else $error("disc section not in standby");

   property p_dir;
      @(posedge clk) disable iff (rst)
         r_reg.pin_oe == (port_use(r_reg.ctrl.osc_mode) & r_reg.ctrl.dir);
   endproperty
   a_dir: assert property (p_dir) else $error("pin drive does not follow direction");

   property p_pull;
      @(posedge clk) disable iff (rst)
         ((r_reg.pu | r_reg.pd) & r_reg.pin_oe) == '0 && (r_reg.pu & r_reg.pd) == '0;
   endproperty
   a_pull: assert property (p_pull) else $error("pull on driven pin or both pulls");

   property p_wake;
      @(posedge clk) disable iff (rst)
         (r_reg.state == RSC_S_HALT && wake && !sys_rst)
         |=> r_reg.state == RSC_S_STANDBY && r_reg.wake_flag;
   endproperty
   a_wake: assert property (p_wake) else $error("pin change did not end clock stop");

   property p_reset_pins;
      @(posedge clk) disable iff (rst)
         sys_rst |=> r_reg.ctrl == RSC_CTRL_RST && r_reg.pin_oe == '0 && !r_reg.req_sub;
   endproperty
   a_reset_pins: assert property (p_reset_pins) else $error("pins not back to inputs");

   property p_halt_osc;
      @(posedge clk) disable iff (rst)
         r_reg.state == RSC_S_HALT |-> !r_reg.sub_xtal_en && !r_reg.rc_osc_en;
   endproperty
   a_halt_osc: assert property (p_halt_osc) else $error("sub oscillator runs in clock stop");
endmodule
